//--- logic/mia_regs.vh
// Register map, field positions and reset values of the indirect access block
// Function
// R01: Read-only high identifier word at address 0x2, all sixteen bits.
// R02: Low identifier word at 0x3 shows six identifier bits in [15:10].
// R03: Low identifier word shows strapped model code [9:4], revision [3:0].
// R04: Control 0xD function [15:14]: 00 address, 01 data without increment.
// R05: Function 10 increments after reads and writes; 11 after writes only.
// R06: Control bits [4:0] select which device the data register reaches.
// R07: Address/data register at 0xE, sixteen bits, read/write, resets zero.
// R08: Device 0x01 reaches PMA/PMD space, control at 0x0000 reset zero.
// R09: Device 0x03 reaches PCS space, control at 0x0000 reset zero.
// R10: Device 0x07 reaches autonegotiation space, control 0x0200 reset 0x1000.
// R11: Address mode write stores address; data modes move register contents.
// R12: Control bits [13:5] ignore writes and read as zero.
`ifndef MIA_REGS_VH
`define MIA_REGS_VH
`define MIA_ADDR_ID_HIGH 5'h02
`define MIA_ADDR_ID_LOW 5'h03
`define MIA_ADDR_CONTROL 5'h0d
`define MIA_ADDR_DATA 5'h0e
`define MIA_FUNC_HI 15
`define MIA_FUNC_LO 14
`define MIA_DEV_HI 4
`define MIA_DEV_LO 0
`define MIA_FUNC_ADDRESS 2'h0
`define MIA_FUNC_DATA 2'h1
`define MIA_FUNC_INC_RW 2'h2
`define MIA_FUNC_INC_W 2'h3
`define MIA_DEV_PMA 5'h01
`define MIA_DEV_PCS 5'h03
`define MIA_DEV_AN 5'h07
`define MIA_REG_PMA_CTRL 16'h0000
`define MIA_REG_PCS_CTRL 16'h0000
`define MIA_REG_AN_CTRL 16'h0200
`define MIA_RST_CONTROL 16'h0000
`define MIA_RST_DATA 16'h0000
`define MIA_RST_PMA_CTRL 16'h0000
`define MIA_RST_PCS_CTRL 16'h0000
`define MIA_RST_AN_CTRL 16'h1000
`endif

//--- logic/mia_mmd_space.v
// Small store of the reachable extended device control registers
`timescale 1ns/1ps
`include "mia_regs.vh"
module mia_mmd_space
(
    input wire clk_i,
    input wire rst_i,
    input wire [4:0] dev_i,
    input wire [15:0] addr_i,
    input wire wr_i,
    input wire [15:0] wdata_i,
    output wire [15:0] rdata_o
);
    reg [15:0] pma_ctrl;
    reg [15:0] pcs_ctrl;
    reg [15:0] an_ctrl;
    reg [15:0] rd;
    wire hit_pma;
    wire hit_pcs;
    wire hit_an;

    // R08 PMA decode
    assign hit_pma = (dev_i == `MIA_DEV_PMA) && (addr_i == `MIA_REG_PMA_CTRL);
    // R09 PCS decode
    assign hit_pcs = (dev_i == `MIA_DEV_PCS) && (addr_i == `MIA_REG_PCS_CTRL);
    // R10 autonegotiation decode
    assign hit_an = (dev_i == `MIA_DEV_AN) && (addr_i == `MIA_REG_AN_CTRL);

    // Control registers, reset to their documented values
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pma_ctrl <= `MIA_RST_PMA_CTRL;
            pcs_ctrl <= `MIA_RST_PCS_CTRL;
            an_ctrl <= `MIA_RST_AN_CTRL;
        end
        else if (wr_i)
        begin
            if (hit_pma)
                pma_ctrl <= wdata_i;
            if (hit_pcs)
                pcs_ctrl <= wdata_i;
            if (hit_an)
                an_ctrl <= wdata_i;
        end
    end

    // Unmapped locations read zero; writes to them are dropped
    always @*
    begin
        rd = 16'h0000;
        if (hit_pma)
            rd = pma_ctrl;
        if (hit_pcs)
            rd = pcs_ctrl;
        if (hit_an)
            rd = an_ctrl;
    end
    assign rdata_o = rd;
endmodule

//--- logic/mia_indirect_access.v
// Identifier words and indirect access to the extended register space
`timescale 1ns/1ps
`include "mia_regs.vh"
module mia_indirect_access
#(
    parameter [15:0] ID_HIGH = 16'h1234,   // Arbitrary identifier value
    parameter [5:0] ID_LOW_BITS = 6'h15,   // Arbitrary identifier value
    parameter [3:0] REVISION = 4'h2        // Arbitrary revision value
)
(
    input wire CLOCK_I,
    input wire SYS_RST_I,
    input wire [5:0] MODEL_PINS_I,
    input wire [4:0] REG_ADDR_I,
    input wire REG_WR_I,
    input wire REG_RD_I,
    input wire [15:0] REG_WDATA_I,
    output wire [15:0] REG_RDATA_O,
    output wire REG_RVALID_O
);
    reg [5:0] model_meta;
    reg [5:0] model_sync;
    reg [5:0] model_code;
    reg strap_taken;
    reg [1:0] indirect_access_function;
    reg [4:0] target_device_select;
    reg [15:0] mmd_address;
    reg [15:0] rdata;
    reg rvalid;
    reg [1:0] next_function;
    reg [4:0] next_device_select;
    reg [15:0] next_address;
    reg [15:0] next_rdata;
    wire [15:0] mmd_rdata;
    wire hit_ctrl;
    wire hit_data;
    wire wr_ctrl;
    wire wr_data;
    wire rd_data;
    wire data_mode;
    wire acc_data_wr;
    wire acc_data_rd;
    wire advance;
    wire [15:0] ctrl_view;
    wire [15:0] id_low_view;
    wire [15:0] data_view;

    // Reset image of the control register, split into its two fields
    localparam [15:0] RST_CONTROL = `MIA_RST_CONTROL;

    // One register address against one strobe address
    function reg_hit;
        input [4:0] addr;
        input [4:0] target;
        begin
            reg_hit = (addr == target);
        end
    endfunction

    // Post-increment of one function code for one kind of data access
    function post_increment;
        input [1:0] func;
        input is_wr;
        input is_rd;
        begin
            // Codes 10 and 11 differ only in whether a read moves the address
            case (func)
                `MIA_FUNC_INC_RW: post_increment = is_wr | is_rd;
                `MIA_FUNC_INC_W: post_increment = is_wr;
                // Address mode and plain data mode never move the address
                default: post_increment = 1'b0;
            endcase
        end
    endfunction

    // R03 strap synchroniser
    // Pins cross two flops; nothing but model_sync reads model_meta
    always @(posedge CLOCK_I)
    begin
        model_meta <= MODEL_PINS_I;
        model_sync <= model_meta;
    end

    // R03 model code capture
    // Caught once after reset, so a strap moving later cannot disturb reads
    always @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            strap_taken <= 1'b0;
            model_code <= 6'h00;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            model_code <= model_sync;
        end
    end

    // Register decode; writes to any other address are dropped
    // Only the two indirect registers react to writes; identifiers are fixed
    assign hit_ctrl = reg_hit(REG_ADDR_I, `MIA_ADDR_CONTROL);
    assign hit_data = reg_hit(REG_ADDR_I, `MIA_ADDR_DATA);
    assign wr_ctrl = REG_WR_I && hit_ctrl;
    assign wr_data = REG_WR_I && hit_data;
    assign rd_data = REG_RD_I && hit_data;

    // R04 code 00 addresses, every other code moves register contents
    assign data_mode = (indirect_access_function != `MIA_FUNC_ADDRESS);
    assign acc_data_wr = wr_data && data_mode;
    assign acc_data_rd = rd_data && data_mode;

    // R05 increment policy
    assign advance = post_increment(indirect_access_function, acc_data_wr, acc_data_rd);

    // R12 reserved bits zero
    assign ctrl_view = {indirect_access_function, 9'h000, target_device_select};

    // Next control fields and stored address
    // A write and a read in one cycle both see the old contents
    always @*
    begin
        // Hold by default
        next_function = indirect_access_function;
        next_device_select = target_device_select;
        next_address = mmd_address;
        if (wr_ctrl)
        begin
            // R04 function field
            next_function = REG_WDATA_I[`MIA_FUNC_HI:`MIA_FUNC_LO];
            // R06 device select
            next_device_select = REG_WDATA_I[`MIA_DEV_HI:`MIA_DEV_LO];
        end
        // R11 address capture
        if (wr_data && !data_mode)
        begin
            next_address = REG_WDATA_I;
        end
        // R05 post increment after the access, wrapping at the top
        else if (advance)
        begin
            next_address = mmd_address + 16'h0001;
        end
    end

    // Control and address registers; reserved control bits are never stored
    always @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            indirect_access_function <= RST_CONTROL[`MIA_FUNC_HI:`MIA_FUNC_LO];
            target_device_select <= RST_CONTROL[`MIA_DEV_HI:`MIA_DEV_LO];
            // R07 address/data register resets to zero
            mmd_address <= `MIA_RST_DATA;
        end
        else
        begin
            indirect_access_function <= next_function;
            target_device_select <= next_device_select;
            // R07 read/write address/data register
            mmd_address <= next_address;
        end
    end

    // R11 data transfer
    // Writes reach the store only in data modes; the address mode never does
    mia_mmd_space u_space
    (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .dev_i(target_device_select),
        .addr_i(mmd_address),
        .wr_i(acc_data_wr),
        .wdata_i(REG_WDATA_I),
        .rdata_o(mmd_rdata)
    );

    // R02 R03 low identifier
    assign id_low_view = {ID_LOW_BITS, model_code, REVISION};

    // Address mode reads the stored address back, data modes the MMD word
    assign data_view = data_mode ? mmd_rdata : mmd_address;

    // Read mux; unmapped addresses answer zero
    always @*
    begin
        next_rdata = 16'h0000;
        case (REG_ADDR_I)
            // R01 high identifier
            `MIA_ADDR_ID_HIGH: next_rdata = ID_HIGH;
            `MIA_ADDR_ID_LOW: next_rdata = id_low_view;
            // R12 control readback
            `MIA_ADDR_CONTROL: next_rdata = ctrl_view;
            // R11 indirect register
            `MIA_ADDR_DATA: next_rdata = data_view;
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read answer one cycle after the strobe
    // Data holds between reads, so a slow host may pick it up late
    always @(posedge CLOCK_I)
    begin
        if (SYS_RST_I)
        begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end
        else
        begin
            // Both strobes in one cycle still give a single answer
            rvalid <= REG_RD_I;
            if (REG_RD_I)
            begin
                rdata <= next_rdata;
            end
        end
    end

    assign REG_RDATA_O = rdata;
    assign REG_RVALID_O = rvalid;
endmodule

//--- sim/mia_host.sv
// Management host model driving single-cycle register strobes
`timescale 1ns/1ps
module mia_host(output logic [4:0] addr_o = 5'h00, output logic wr_o = 1'b0,
    output logic rd_o = 1'b0, output logic [15:0] wdata_o = 16'h0000);
    task put(logic [4:0] a, logic w, logic r, logic [15:0] d);
        wr_o = w;
        rd_o = r;
        // Idle lines toggle so stale values never look valid
        addr_o = w | r ? a : ~addr_o;
        wdata_o = w ? d : ~wdata_o;
    endtask
endmodule

//--- sim/mia_assertions.sv
// Port checks of the indirect access block
`timescale 1ns/1ps
module mia_chk #(parameter [15:0] ID_HIGH = 16'h1234, parameter [5:0] ID_LOW_BITS = 6'h15,
    parameter [3:0] REVISION = 4'h2)
(input wire CLOCK_I, input wire SYS_RST_I, input wire [5:0] MODEL_PINS_I,
    input wire [4:0] REG_ADDR_I, input wire REG_WR_I, input wire REG_RD_I,
    input wire [15:0] REG_WDATA_I, input wire [15:0] REG_RDATA_O, input wire REG_RVALID_O);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    a_answer_next: assert property (REG_RD_I |=> REG_RVALID_O)
        else $error("read answer missing");
    a_no_spurious: assert property (!REG_RD_I |=> !REG_RVALID_O)
        else $error("answer without read");
    a_data_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
        else $error("read data moved");
    a_id_high: assert property (REG_RD_I && REG_ADDR_I == 5'h02 |=> REG_RDATA_O == ID_HIGH)
        else $error("high identifier wrong");
    a_id_low: assert property (REG_RD_I && REG_ADDR_I == 5'h03 |=>
        REG_RDATA_O[15:10] == ID_LOW_BITS && REG_RDATA_O[3:0] == REVISION)
        else $error("low identifier wrong");
    a_model_code: assert property (REG_RD_I && REG_ADDR_I == 5'h03 |=>
        REG_RDATA_O[9:4] == $past(MODEL_PINS_I))
        else $error("model code wrong");
    a_reserved_zero: assert property (REG_RD_I && REG_ADDR_I == 5'h0d |=>
        REG_RDATA_O[13:5] == 9'h000)
        else $error("reserved bits set");
    a_ctrl_back: assert property ((REG_WR_I && REG_ADDR_I == 5'h0d) ##1
        (REG_RD_I && !REG_WR_I && REG_ADDR_I == 5'h0d) |=>
        REG_RDATA_O == ($past(REG_WDATA_I, 2) & 16'hc01f))
        else $error("control readback wrong");
endmodule
bind mia_indirect_access mia_chk #(.ID_HIGH(ID_HIGH), .ID_LOW_BITS(ID_LOW_BITS),
    .REVISION(REVISION)) u_chk(.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .MODEL_PINS_I(MODEL_PINS_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I),
    .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
    .REG_RVALID_O(REG_RVALID_O));

//--- sim/testbench.sv
// Random traffic against a reference model of the indirect access block
`timescale 1ns/1ps
module testbench;
    logic clk = 0;
    logic rst = 1;
    logic [5:0] pins;
    wire [4:0] a;
    wire wr, rd, rv;
    wire [15:0] wd, rdata;
    int mismatches = 0;
    int n_tests = 0;
    logic [15:0] ctrl, madr, exp, mem[int];
    bit pend;
    initial forever #20 clk = ~clk;
    mia_host host(.addr_o(a), .wr_o(wr), .rd_o(rd), .wdata_o(wd));
    mia_indirect_access uut(.CLOCK_I(clk), .SYS_RST_I(rst), .MODEL_PINS_I(pins),
        .REG_ADDR_I(a), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wd),
        .REG_RDATA_O(rdata), .REG_RVALID_O(rv));
    task check(string nm, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task do_reset();
        host.put(0, 0, 0, 0);
        rst = 1;
        // New strap value each reset; it settles long before release
        pins = $urandom;
        repeat (5) @(negedge clk);
        rst = 0;
        ctrl = 0;
        madr = 0;
        pend = 0;
        mem.delete();
        mem[32'h10000] = 0;
        mem[32'h30000] = 0;
        mem[32'h70200] = 16'h1000;
    endtask
    // Answer of the access put on the lines at the previous falling edge
    task collect();
        @(negedge clk);
        check("rvalid", pend, rv);
        if (pend)
            check("rdata", exp, rdata);
        pend = 0;
    endtask
    task step();
        int k, f, op;
        bit w, r;
        logic [4:0] ad;
        logic [15:0] d, e;
        collect();
        k = $urandom % 8;
        // Code 3 raises both strobes; the read must see the old contents
        op = $urandom % 4;
        w = op == 0 || op == 3;
        r = op == 1 || op == 3;
        ad = k < 2 ? 5'(k + 2) : k < 4 ? 5'h0d : k < 7 ? 5'h0e : 5'($urandom);
        d = $urandom;
        if (ad == 5'h0d)
            d[4:0] = k == 2 ? 5'h01 : $urandom % 2 ? 5'h03 : 5'h07;
        if (ad == 5'h0e && $urandom % 2)
            d = $urandom % 2 ? 16'h0200 : 16'hffff;
        f = ctrl[15:14];
        k = {ctrl[4:0], madr};
        // Arbitrary identifier values of the default build
        e = ad == 5'h02 ? 16'h1234 : ad == 5'h03 ? {6'h15, pins, 4'h2} : ad == 5'h0d ? ctrl
            : ad == 5'h0e ? (f == 0 ? madr : mem.exists(k) ? mem[k] : 16'h0000) : 16'h0000;
        host.put(ad, w, r, d);
        pend = r;
        exp = e;
        if (w && ad == 5'h0d)
            ctrl = d & 16'hc01f;
        else if (w && ad == 5'h0e && f == 0)
            madr = d;
        else if (w && ad == 5'h0e)
        begin
            if (mem.exists(k))
                mem[k] = d;
            madr += f > 1;
        end
        else if (r && ad == 5'h0e && f == 2)
            madr++;
    endtask
    task report_and_stop();
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Two runs, the second after a reset once the last answer has been collected
    initial
    begin
        pins = $urandom(32'h16c7f13c);
        repeat (2)
        begin
            do_reset();
            repeat (600) step();
            collect();
        end
        report_and_stop();
    end
endmodule
